// ===== pkg/sacw_pkg.sv
/*
 register map, field positions, reset values and timing counts for the
 converter control block. assumes an 8-bit special function register port.
*/
package sacw_pkg;
   // register offsets (byte addresses on the sfr port)
   localparam logic [7:0] OFS_RES_LOW   = 8'hbe; // result low byte
   localparam logic [7:0] OFS_RES_HIGH  = 8'hbf; // result high byte
   localparam logic [7:0] OFS_CFG       = 8'hbc; // converter_config
   localparam logic [7:0] OFS_GT_LOW    = 8'hc4; // greater-than low
   localparam logic [7:0] OFS_GT_HIGH   = 8'hc5; // greater-than high
   localparam logic [7:0] OFS_LT_LOW    = 8'hc6; // less-than low
   localparam logic [7:0] OFS_LT_HIGH   = 8'hc7; // less-than high
   localparam logic [7:0] OFS_CTRL      = 8'he8; // converter_control
   localparam logic [7:0] OFS_PAIR_CFG  = 8'hba; // pair_config_reg
   localparam logic [7:0] OFS_CHAN_SEL  = 8'hbb; // channel_select_reg
   // reset values
   localparam logic [7:0] RST_CTRL      = 8'h00;
   localparam logic [7:0] RST_CFG       = 8'h60;
   localparam logic [7:0] RST_GT_BYTE   = 8'hff;
   localparam logic [7:0] RST_LT_BYTE   = 8'h00;
   localparam logic [7:0] RST_RES       = 8'h00;
   // control bit positions
   localparam int CTL_ON     = 7;
   localparam int CTL_TRACK  = 6;
   localparam int CTL_DONE   = 5;
   localparam int CTL_BUSY   = 4;
   localparam int CTL_SRC_HI = 3;
   localparam int CTL_SRC_LO = 2;
   localparam int CTL_WIN    = 1;
   localparam int CTL_LJ     = 0;
   // config fields
   localparam int CFG_DIV_HI  = 7;
   localparam int CFG_DIV_LO  = 5;
   localparam int CFG_GAIN_HI = 2;
   localparam int CFG_GAIN_LO = 0;
   // timing in sar clocks
   localparam logic [4:0] CONV_SAR_CLKS  = 5'd16;
   localparam logic [4:0] TRACK_SAR_CLKS = 5'd3;
   // start source codes
   localparam logic [1:0] SRC_SOFT  = 2'h0;
   localparam logic [1:0] SRC_TMR3  = 2'h1;
   localparam logic [1:0] SRC_EXT   = 2'h2;
   localparam logic [1:0] SRC_TMR2  = 2'h3;
   // sfr bus request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sacw_sfr_s;
   // analog core handshake
   typedef struct packed {
      logic        done;
      logic [11:0] code;
   } sacw_core_s;
   // converter sequencing states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_TRACK = 3'b010,
      ST_CONV  = 3'b100
   } sacw_state_e;
endpackage

// ===== hw/sacw_clkdiv.sv
/*
 sar clock enable divider: one-cycle tick every 1/2/4/8/16 system clocks.
 assumes the divider field is static while conversions run.
*/
module sacw_clkdiv
   import sacw_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   input  wire logic       run,      // count only when converter is on
   input  wire logic [2:0] div_code, // conv_clock_divider field
   output logic            sar_tick  // one pulse per sar clock
);
   logic [3:0] cnt_r;  // free divider count
   logic [3:0] mask;   // terminal count for the code

   // decode code to terminal count
   always_comb
   begin
      case (div_code)
         3'h0:    mask = 4'h0;
         3'h1:    mask = 4'h1;
         3'h2:    mask = 4'h3;
         3'h3:    mask = 4'h7;
         default: mask = 4'hf; // top bit set divides by sixteen
      endcase
   end

   // divider counter
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         cnt_r <= 4'h0;
      else if (!run || cnt_r >= mask)
         cnt_r <= 4'h0;
      else
         cnt_r <= cnt_r + 4'h1;
   end

   assign sar_tick = run && (cnt_r >= mask);
endmodule // sacw_clkdiv

// ===== hw/sacw_top.sv
/*
 control logic for a 12-bit sar converter: sfr registers, start sources,
 track/convert sequencing, justification and the window comparator.
 assumes the analog core delivers a 12-bit code by the end of the 16th sar
 clock and that timer overflows are one-cycle pulses in the sys_clk domain.
*/
module sacw_top
(
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   input  sacw_pkg::sacw_sfr_s  sfr_req,     // sfr access, same clock
   output logic [7:0]       sfr_rdata,       // registered read data
   input  wire logic        tmr2_ovf,        // timer 2 overflow pulse
   input  wire logic        tmr3_ovf,        // timer 3 overflow pulse
   input  wire logic        ext_convert_start, // pin, asynchronous
   input  wire logic        diff_channel,    // selected channel is a pair
   input  sacw_pkg::sacw_core_s core_in,     // analog core result
   output logic             converter_on,    // powers converter, t/h, amp
   output logic             track_en,        // track-and-hold tracking
   output logic             convert_en,      // sar conversion running
   output logic             sar_clk_tick,    // sar clock strobe to core
   output logic [2:0]       amp_gain_select, // gain code to amplifier
   output logic [7:0]       pair_config,     // pair configuration bits
   output logic [3:0]       channel_select,  // mux address
   output logic             conv_irq         // converter interrupt request
);
   import sacw_pkg::*;

   logic [7:0]  ctrl_r;       // converter_control
   logic [7:0]  cfg_r;        // converter_config
   logic [7:0]  gt_lo_r;      // greater-than low byte
   logic [7:0]  gt_hi_r;      // greater-than high byte
   logic [7:0]  lt_lo_r;      // less-than low byte
   logic [7:0]  lt_hi_r;      // less-than high byte
   logic [15:0] result_r;     // stored result word
   logic [7:0]  pair_r;       // pair config
   logic [3:0]  chan_r;       // channel select
   logic        irq_en_r;     // local interrupt enable
   logic        ext_s1_r;     // pin sync first stage
   logic        ext_s2_r;     // pin sync second stage
   logic        ext_d_r;      // delayed sync for edge
   logic [4:0]  sar_cnt_r;    // sar clocks in current phase
   logic        finish_r;     // end of conversion pulse
   sacw_state_e state_r;      // sequencer state
   logic        sar_tick;     // divided clock strobe
   logic        start_ev;     // selected start event
   logic [7:0]  ctrl_eff;     // control as this edge leaves it
   logic        wr_ctrl;      // control register written
   logic [15:0] res_nxt;      // justified result
   logic [15:0] gt_word;      // greater-than limit
   logic [15:0] lt_word;      // less-than limit
   logic        below_lt;     // result < less limit
   logic        above_gt;     // result > greater limit
   logic        win_hit;      // window condition met

   sacw_clkdiv u_div
   (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .run      (ctrl_r[CTL_ON]),
      .div_code (cfg_r[CFG_DIV_HI:CFG_DIV_LO]),
      .sar_tick (sar_tick)
   );

   // two-flop sync plus edge history for the start pin
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r  <= 1'b0;
      end
      else
      begin
         ext_s1_r <= ext_convert_start;
         ext_s2_r <= ext_s1_r;
         ext_d_r  <= ext_s2_r;
      end
   end

   assign wr_ctrl    = sfr_req.wr && sfr_req.addr == OFS_CTRL;
   assign ctrl_eff   = wr_ctrl ? sfr_req.wdata : ctrl_r;

   // start source mux; events while disabled or busy are dropped
   always_comb
   begin
      case (ctrl_eff[CTL_SRC_HI:CTL_SRC_LO])
         SRC_SOFT: start_ev = wr_ctrl && sfr_req.wdata[CTL_BUSY];
         SRC_TMR3: start_ev = tmr3_ovf;
         SRC_EXT:  start_ev = ext_s2_r && !ext_d_r;
         SRC_TMR2: start_ev = tmr2_ovf;
         default:  start_ev = 1'b0;
      endcase
   end

   // track/convert sequencer
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r   <= ST_IDLE;
         sar_cnt_r <= 5'd0;
         finish_r  <= 1'b0;
      end
      else
      begin
         finish_r <= 1'b0;
         case (state_r)
            ST_IDLE:
            begin
               sar_cnt_r <= 5'd0;
               // triggered low-power tracking needs three sar clocks first, except for a start from the pin
               if (start_ev && ctrl_eff[CTL_ON])
                  state_r <= (ctrl_eff[CTL_TRACK] &&
                              ctrl_eff[CTL_SRC_HI:CTL_SRC_LO] != SRC_EXT)
                             ? ST_TRACK : ST_CONV;
            end
            ST_TRACK:
            begin
               if (!ctrl_r[CTL_ON])
                  state_r <= ST_IDLE;
               else if (sar_tick && sar_cnt_r == TRACK_SAR_CLKS - 5'd1)
               begin
                  sar_cnt_r <= 5'd0;
                  state_r   <= ST_CONV;
               end
               else if (sar_tick)
                  sar_cnt_r <= sar_cnt_r + 5'd1;
            end
            ST_CONV:
            begin
               if (!ctrl_r[CTL_ON])
                  state_r <= ST_IDLE; // abort, no result
               else if (sar_tick && sar_cnt_r == CONV_SAR_CLKS - 5'd1)
               begin
                  state_r  <= ST_IDLE;
                  finish_r <= 1'b1;
               end
               else if (sar_tick)
                  sar_cnt_r <= sar_cnt_r + 5'd1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // justify the core code: left, or right with sign only for pairs
   assign res_nxt = ctrl_r[CTL_LJ] ? {core_in.code, 4'h0}
                    : {{4{diff_channel && core_in.code[11]}}, core_in.code};
   assign gt_word = {gt_hi_r, gt_lo_r};
   assign lt_word = {lt_hi_r, lt_lo_r};

   // signed compare for pairs, unsigned otherwise; uses justified word
   always_comb
   begin
      if (diff_channel)
      begin
         below_lt = $signed(res_nxt) < $signed(lt_word);
         above_gt = $signed(res_nxt) > $signed(gt_word);
         win_hit  = ($signed(lt_word) > $signed(gt_word))
                    ? (below_lt && above_gt) : (below_lt || above_gt);
      end
      else
      begin
         below_lt = res_nxt < lt_word;
         above_gt = res_nxt > gt_word;
         win_hit  = (lt_word > gt_word)
                    ? (below_lt && above_gt)
                    : (below_lt || above_gt);
      end
   end

   // control register: flags set by hardware win over software clears
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         ctrl_r <= RST_CTRL;
      else
      begin
         if (wr_ctrl)
         begin
            ctrl_r[CTL_ON]    <= sfr_req.wdata[CTL_ON];
            ctrl_r[CTL_TRACK] <= sfr_req.wdata[CTL_TRACK];
            ctrl_r[CTL_SRC_HI:CTL_SRC_LO] <= sfr_req.wdata[CTL_SRC_HI:CTL_SRC_LO];
            ctrl_r[CTL_LJ]    <= sfr_req.wdata[CTL_LJ];
            ctrl_r[CTL_DONE]  <= sfr_req.wdata[CTL_DONE];
            ctrl_r[CTL_WIN]   <= sfr_req.wdata[CTL_WIN];
         end
         ctrl_r[CTL_BUSY] <= (state_r != ST_IDLE) && ctrl_r[CTL_ON];
         if (finish_r)
         begin
            ctrl_r[CTL_DONE] <= 1'b1;
            if (win_hit)
               ctrl_r[CTL_WIN] <= 1'b1;
         end
      end
   end

   // result word: loaded on completion, else software writes to either byte
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         result_r <= {RST_RES, RST_RES};
      else if (finish_r)
         result_r <= res_nxt;
      else if (sfr_req.wr && sfr_req.addr == OFS_RES_HIGH)
         result_r[15:8] <= sfr_req.wdata;
      else if (sfr_req.wr && sfr_req.addr == OFS_RES_LOW)
         result_r[7:0] <= sfr_req.wdata;
   end

   // plain software registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_r    <= RST_CFG;
         gt_lo_r  <= RST_GT_BYTE;
         gt_hi_r  <= RST_GT_BYTE;
         lt_lo_r  <= RST_LT_BYTE;
         lt_hi_r  <= RST_LT_BYTE;
         pair_r   <= 8'h00;
         chan_r   <= 4'h0;
         irq_en_r <= 1'b0;
      end
      else if (sfr_req.wr)
      begin
         case (sfr_req.addr)
            OFS_CFG:      cfg_r   <= sfr_req.wdata & 8'he7; // bits 4-3 unused
            OFS_GT_LOW:   gt_lo_r <= sfr_req.wdata;
            OFS_GT_HIGH:  gt_hi_r <= sfr_req.wdata;
            OFS_LT_LOW:   lt_lo_r <= sfr_req.wdata;
            OFS_LT_HIGH:  lt_hi_r <= sfr_req.wdata;
            OFS_PAIR_CFG: pair_r  <= {4'h0, sfr_req.wdata[3:0]};
            OFS_CHAN_SEL: chan_r  <= sfr_req.wdata[3:0];
            8'hd0:        irq_en_r <= sfr_req.wdata[0]; // interrupt enable
            default:      irq_en_r <= irq_en_r;
         endcase
      end
   end

   // registered read mux; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         sfr_rdata <= 8'h00;
      else if (sfr_req.rd)
      begin
         case (sfr_req.addr)
            OFS_CTRL:     sfr_rdata <= ctrl_r;
            OFS_CFG:      sfr_rdata <= cfg_r;
            OFS_RES_HIGH: sfr_rdata <= result_r[15:8];
            OFS_RES_LOW:  sfr_rdata <= result_r[7:0];
            OFS_GT_LOW:   sfr_rdata <= gt_lo_r;
            OFS_GT_HIGH:  sfr_rdata <= gt_hi_r;
            OFS_LT_LOW:   sfr_rdata <= lt_lo_r;
            OFS_LT_HIGH:  sfr_rdata <= lt_hi_r;
            OFS_PAIR_CFG: sfr_rdata <= pair_r;
            OFS_CHAN_SEL: sfr_rdata <= {4'h0, chan_r};
            8'hd0:        sfr_rdata <= {7'h00, irq_en_r};
            default:      sfr_rdata <= 8'h00;
         endcase
      end
   end

   assign converter_on    = ctrl_r[CTL_ON];
   // continuous tracking outside conversion, or triggered windows
   assign track_en = ctrl_r[CTL_ON] && (ctrl_r[CTL_TRACK]
                     ? ((ctrl_r[CTL_SRC_HI:CTL_SRC_LO] == SRC_EXT)
                        ? (!ext_s2_r && state_r == ST_IDLE)
                        : state_r == ST_TRACK)
                     : state_r != ST_CONV);
   assign convert_en      = state_r == ST_CONV;
   assign sar_clk_tick    = sar_tick;
   assign amp_gain_select = cfg_r[CFG_GAIN_HI:CFG_GAIN_LO];
   assign pair_config     = pair_r;
   assign channel_select  = chan_r;
   assign conv_irq        = irq_en_r && ctrl_r[CTL_DONE];
endmodule // sacw_top

// ===== dv/sacw_core_model.sv
/*
 behavioural stand-in for the analog sample-and-hold and sar core.
 assumes convert_en frames each conversion and the bench sets the code.
*/
module sacw_core_model
   import sacw_pkg::*;
(
   input  wire logic           sys_clk,    // system clock
   input  wire logic           convert_en, // conversion frame from the block
   input  wire logic [11:0]    code_val,   // code the bench wants returned
   output sacw_pkg::sacw_core_s core_in    // code back to the block
);
   timeunit 1ns;
   timeprecision 100ps;
   logic conv_d_r; // one cycle of hold after the frame

   // delayed frame, gives the block a cycle of hold on the code
   always_ff @(posedge sys_clk)
   begin
      conv_d_r <= convert_en;
   end

   // outside the frame the code is stale: show its inverse, not a copy
   assign core_in.done = conv_d_r & ~convert_en;
   assign core_in.code = (convert_en | conv_d_r) ? code_val : ~code_val;
endmodule // sacw_core_model

// ===== dv/sacw_top_monitor.sv
/*
 port-level checker for the converter control block.
 assumes it is bound into sacw_top and sees only its ports.
*/
module sacw_top_monitor
   import sacw_pkg::*;
(
   input  wire logic          sys_clk,         // system clock
   input  wire logic          arst_n,          // async reset, low
   input  sacw_pkg::sacw_sfr_s sfr_req,        // register requests
   input  wire logic          converter_on,    // power enable
   input  wire logic          track_en,        // tracking
   input  wire logic          convert_en,      // conversion running
   input  wire logic          sar_clk_tick,    // sar strobe
   input  wire logic [2:0]    amp_gain_select  // gain code
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] div_r;   // shadow of the divider field
   logic       trk_r;   // shadow of the track mode bit
   logic       gseen_r; // config written since reset
   logic [4:0] tcnt_r;  // sar ticks in the current conversion
   logic       cfg_wr;  // config write strobe
   logic       ctl_wr;  // control write strobe

   assign cfg_wr = sfr_req.wr && (sfr_req.addr == OFS_CFG);
   assign ctl_wr = sfr_req.wr && (sfr_req.addr == OFS_CTRL);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // config shadow, same edge as the design register
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         div_r   <= 3'h3;
         gseen_r <= 1'b0;
      end
      else if (cfg_wr)
      begin
         div_r   <= sfr_req.wdata[7:5];
         gseen_r <= 1'b1;
      end
   end

   // track mode shadow
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         trk_r <= 1'b0;
      else if (ctl_wr)
         trk_r <= sfr_req.wdata[6];
   end

   // tick counter, cleared between conversions
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         tcnt_r <= 5'h00;
      else if (!convert_en)
         tcnt_r <= 5'h00;
      else if (sar_clk_tick)
         tcnt_r <= tcnt_r + 5'h01;
   end

   a_off_no_conv: assert property (!converter_on |-> !convert_en)
      else $error("conversion while converter off");
   a_off_no_track: assert property (!converter_on |-> !track_en)
      else $error("tracking while converter off");
   a_on_from_ctrl: assert property (ctl_wr |=> converter_on == $past(sfr_req.wdata[7]))
      else $error("enable bit not applied");
   a_no_track_conv: assert property (convert_en |-> !track_en)
      else $error("tracking during conversion");
   a_track_idle_cont: assert property (converter_on && !trk_r && !convert_en |-> track_en)
      else $error("continuous tracking missing");
   a_tick_div_one: assert property (convert_en && div_r == 3'h0 |-> sar_clk_tick)
      else $error("divide by one misses a tick");
   a_conv_sixteen: assert property ($fell(convert_en) && converter_on && div_r != 3'h0
      |-> tcnt_r == 5'd16)
      else $error("conversion not sixteen sar clocks");
   a_gain_write: assert property (cfg_wr |=> amp_gain_select == $past(sfr_req.wdata[2:0]))
      else $error("gain field not applied");
   a_gain_unity: assert property (!gseen_r |-> amp_gain_select == 3'h0)
      else $error("gain not unity after reset");
endmodule // sacw_top_monitor

bind sacw_top sacw_top_monitor mon (
   .sys_clk(sys_clk), .arst_n(arst_n), .sfr_req(sfr_req), .converter_on(converter_on),
   .track_en(track_en), .convert_en(convert_en), .sar_clk_tick(sar_clk_tick),
   .amp_gain_select(amp_gain_select));

// ===== dv/testbench.sv
/*
 self-checking bench for the converter control block.
 assumes the core model and the bound checker are compiled before it.
*/
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import sacw_pkg::*;
   // one window case: setup beside the expected outcome
   typedef struct packed {
      logic lj, dif; logic [11:0] code; logic [15:0] gt, lt, res; logic win;
   } sacw_row_s;
   logic       sys_clk, arst_n, tmr2, tmr3, pin, dif, on, trk, conv, tick, irq;
   sacw_sfr_s  req;      // register request
   sacw_core_s core;     // core answer
   logic [7:0] rdata, d, hi; // read data and last read
   logic [2:0] gain;     // gain code out
   logic [3:0] chan;     // mux address out
   logic [7:0] pcfg;     // pair bits out
   logic [11:0] code_val; // code the model returns
   int num_errors = 0;
   int checks = 0;
   int n;
   sacw_row_s rows [8] = '{
      {2'b00, 12'h180, 16'h0100, 16'h0200, 16'h0180, 1'b1},
      {2'b00, 12'h200, 16'h0100, 16'h0200, 16'h0200, 1'b0},
      {2'b00, 12'h0ff, 16'h0200, 16'h0100, 16'h00ff, 1'b1},
      {2'b00, 12'h150, 16'h0200, 16'h0100, 16'h0150, 1'b0},
      {2'b10, 12'h180, 16'h1000, 16'h2000, 16'h1800, 1'b1},
      {2'b01, 12'hfff, 16'hffff, 16'h0100, 16'hffff, 1'b0},
      {2'b01, 12'h000, 16'hffff, 16'h0100, 16'h0000, 1'b1},
      {2'b11, 12'h800, 16'h1000, 16'hfff0, 16'h8000, 1'b1}};
   int per [6] = '{1, 2, 4, 8, 16, 16}; // sar period per divider step
   logic [2:0] divs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
   logic [15:0] rst_tab [9] = '{16'he800, 16'hbc60, 16'hc4ff, 16'hc5ff, 16'hc600,
      16'hc700, 16'hbf00, 16'hbe00, 16'h0000}; // address : value after reset

   sacw_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .sfr_req(req), .sfr_rdata(rdata),
      .tmr2_ovf(tmr2), .tmr3_ovf(tmr3), .ext_convert_start(pin), .diff_channel(dif),
      .core_in(core), .converter_on(on), .track_en(trk), .convert_en(conv),
      .sar_clk_tick(tick), .amp_gain_select(gain), .pair_config(pcfg), .channel_select(chan),
      .conv_irq(irq));
   sacw_core_model core_m (.sys_clk(sys_clk), .convert_en(conv), .code_val(code_val),
      .core_in(core));

   // free-running 100 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic final_report;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // a hang counts as a mismatch and ends the run
   task automatic timeout;
      chk(16'hdead, 16'h0000);
      final_report();
   endtask

   // one idle edge after each access, so strobes never collide
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req <= '{1'b1, 1'b0, a, v};
      @(posedge sys_clk);
      req <= '0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      req <= '0;
      #1 d = rdata;
   endtask

   // polls the done flag; it stays set until software clears it
   task automatic wait_done;
      int m;
      m = 0;
      rd(OFS_CTRL);
      while (d[5] !== 1'b1)
      begin
         if (++m > 400) timeout();
         else rd(OFS_CTRL);
      end
   endtask

   // pulse one start source: 1 timer 3, 2 pin, 3 timer 2
   task automatic fire(input int k);
      @(posedge sys_clk);
      tmr3 <= (k == 1);
      pin  <= (k == 2);
      tmr2 <= (k == 3);
      @(posedge sys_clk);
      tmr3 <= 1'b0;
      tmr2 <= 1'b0;
      repeat (4) @(posedge sys_clk);
      pin <= 1'b0;
   endtask

   initial
   begin
      req = '0;
      {tmr2, tmr3, pin, dif} = 4'h0;
      code_val = 12'h000;
      arst_n = 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      wr(OFS_CFG, 8'h00);
      // window, justification and sign cases
      foreach (rows[i])
      begin
         dif <= rows[i].dif;
         code_val <= rows[i].code;
         wr(OFS_GT_HIGH, rows[i].gt[15:8]);
         wr(OFS_GT_LOW, rows[i].gt[7:0]);
         wr(OFS_LT_HIGH, rows[i].lt[15:8]);
         wr(OFS_LT_LOW, rows[i].lt[7:0]);
         wr(OFS_CTRL, {7'h48, rows[i].lj});
         wait_done();
         chk({15'h0, d[1]}, {15'h0, rows[i].win});
         chk({14'h0, d[5:4]}, 16'h0002);
         rd(OFS_RES_HIGH);
         hi = d;
         rd(OFS_RES_LOW);
         chk({hi, d}, rows[i].res);
      end
      // hardware start sources; a foreign trigger must not start
      for (int s = 1; s < 4; s++)
      begin
         wr(OFS_CTRL, {4'h8, 2'(s), 2'b00});
         fire(s % 3 + 1);
         repeat (40) @(posedge sys_clk);
         rd(OFS_CTRL);
         chk({15'h0, d[5]}, 16'h0000);
         fire(s);
         wait_done();
         chk({15'h0, d[4]}, 16'h0000);
      end
      // sar clock period for every divider step
      foreach (divs[i])
      begin
         wr(OFS_CFG, {divs[i], 5'h00});
         wr(OFS_CTRL, 8'h90);
         n = 0;
         while (!(conv === 1'b1 && tick === 1'b1))
         begin
            @(negedge sys_clk);
            if (++n > 300) timeout();
         end
         n = 0;
         do
         begin
            @(negedge sys_clk);
            n++;
         end
         while (tick !== 1'b1 && n < 40);
         chk(16'(n), 16'(per[i]));
         wait_done();
      end
      // low-power tracking: three sar clocks at divide by one
      wr(OFS_CFG, 8'h00);
      wr(OFS_CTRL, 8'hd0);
      n = 0;
      repeat (40)
      begin
         @(negedge sys_clk);
         if (trk === 1'b1) n++;
      end
      chk(16'(n), 16'h0003);
      wait_done();
      // converter off: a start request is ignored
      wr(OFS_CTRL, 8'h10);
      repeat (30) @(negedge sys_clk);
      chk({13'h0, on, trk, conv}, 16'h0000);
      rd(OFS_CTRL);
      chk({15'h0, d[5]}, 16'h0000);
      // interrupt request follows the done flag
      wr(8'hd0, 8'h01);
      wr(OFS_CTRL, 8'h90);
      wait_done();
      chk({15'h0, irq}, 16'h0001);
      wr(OFS_CTRL, 8'h80);
      repeat (2) @(negedge sys_clk);
      chk({15'h0, irq}, 16'h0000);
      // pair bits, mux address and a non-unity gain reach their outputs
      wr(OFS_PAIR_CFG, 8'hff);
      wr(OFS_CHAN_SEL, 8'h39);
      wr(OFS_CFG, 8'h06);
      @(negedge sys_clk);
      chk({1'b0, gain, chan, pcfg}, 16'h690f);
      // second reset in mid-conversion, then every package reset value and the gain
      wr(OFS_CTRL, 8'h90);
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      arst_n <= 1'b1;
      foreach (rst_tab[i])
      begin
         rd(rst_tab[i][15:8]);
         chk({8'h00, d}, {8'h00, rst_tab[i][7:0]});
      end
      chk({13'h0, gain}, 16'h0000);
      final_report();
   end
endmodule // testbench
